// ---- verilog/aar_alarm.v ----
// Alarm comparison, flags and serial frame logic of the converter
`include "aar_map.vh"
module aar_alarm #(
    parameter CONV_CYC = `AAR_CONV_CYC
) (
    mclk,
    rst,
    conv_result,
    conv_result_valid,
    conv_result_ready,
    high_threshold,
    low_threshold,
    hysteresis,
    multifunction_pin_select,
    input_alarm_disable,
    supply_alarm_disable,
    internal_ref_disable_in,
    internal_ref_disable_we,
    append_flags,
    supply_over_trip,
    supply_under_trip,
    convert_start_chip_select,
    sclk,
    sdi,
    primary_serial_output,
    primary_serial_output_oe,
    shared_alarm_output_pin,
    internal_ref_disable,
    converting,
    conv_start,
    alarm_flags,
    frame_rx_word,
    frame_rx_valid,
    result_code
);
    input wire mclk;
    input wire rst;
    input wire [`AAR_RES_W-1:0] conv_result;
    input wire conv_result_valid;
    output wire conv_result_ready;
    input wire [`AAR_RES_W-1:0] high_threshold;
    input wire [`AAR_RES_W-1:0] low_threshold;
    input wire [`AAR_RES_W-1:0] hysteresis;
    input wire [1:0] multifunction_pin_select;
    input wire input_alarm_disable;
    input wire supply_alarm_disable;
    input wire internal_ref_disable_in;
    input wire internal_ref_disable_we;
    input wire append_flags;
    input wire supply_over_trip;
    input wire supply_under_trip;
    input wire convert_start_chip_select;
    input wire sclk;
    input wire sdi;
    output reg primary_serial_output;
    output reg primary_serial_output_oe;
    output reg shared_alarm_output_pin;
    output reg internal_ref_disable;
    output reg converting;
    output reg conv_start;
    output reg [`AAR_FLAGS_W-1:0] alarm_flags;
    output reg [`AAR_FRAME_W-1:0] frame_rx_word;
    output reg frame_rx_valid;
    output reg [`AAR_RES_W-1:0] result_code;

    // Pin synchronisers, edge delays and block state registers
    reg [1:0] cs_s_r;
    reg [1:0] sck_s_r;
    reg [1:0] sdi_s_r;
    reg cs_d_r;
    reg sck_d_r;
    reg si_r;
    reg [1:0] ovr_s_r;
    reg [1:0] und_s_r;
    reg [3:0] act_r;
    reg [3:0] trip_r;
    reg [`AAR_CNT_W+4:0] conv_cnt_r;
    reg [`AAR_FRAME_W-1:0] sh_r;
    reg [`AAR_CNT_W-1:0] bit_cnt_r;
    reg rd_flags_r;

    wire cs_q;
    wire sck_q;
    wire cs_rise;
    wire cs_fall;
    wire sck_rise;
    wire sck_fall;
    wire conv_done;
    wire [`AAR_RES_W-1:0] fifo_data;
    wire fifo_valid;
    wire [`AAR_RES_W:0] hi_lim;
    wire [`AAR_RES_W:0] lo_lim;
    wire in_hi_set;
    wire in_hi_clr;
    wire in_lo_set;
    wire in_lo_clr;
    wire [3:0] en_mask;
    reg [3:0] cond;
    reg [`AAR_FRAME_W-1:0] load_word;

    assign cs_q = cs_s_r[1];
    assign sck_q = sck_s_r[1];
    assign cs_rise = cs_q && !cs_d_r;
    assign cs_fall = !cs_q && cs_d_r;
    assign sck_rise = sck_q && !sck_d_r;
    assign sck_fall = !sck_q && sck_d_r;
    assign en_mask = {{2{~supply_alarm_disable}}, {2{~input_alarm_disable}}};
    assign conv_done = converting && (conv_cnt_r == {(`AAR_CNT_W+5){1'b0}}) && fifo_valid;

    aar_fifo #(
        .WIDTH(`AAR_RES_W),
        .DEPTH(`AAR_FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_data(conv_result),
        .in_valid(conv_result_valid),
        .in_ready(conv_result_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(conv_done)
    );

    // Unsigned compare with widened limits; hysteresis shared by both
    assign hi_lim = {1'b0, high_threshold} - {1'b0, hysteresis} - `AAR_ONE17;
    assign lo_lim = {1'b0, low_threshold} + {1'b0, hysteresis} + `AAR_ONE17;
    assign in_hi_set = fifo_data > high_threshold;
    assign in_hi_clr = !hi_lim[`AAR_RES_W] && ({1'b0, fifo_data} <= hi_lim);
    assign in_lo_set = fifo_data < low_threshold;
    assign in_lo_clr = lo_lim[`AAR_RES_W] ? 1'b0 : ({1'b0, fifo_data} >= lo_lim);

    // Conditions at conversion end: bit0 in high, bit1 in low, bit2 supply high, bit3 low
    always @* begin
        cond[0] = !input_alarm_disable && (in_hi_set || (act_r[0] && !in_hi_clr));
        cond[1] = !input_alarm_disable && (in_lo_set || (act_r[1] && !in_lo_clr));
        cond[2] = !supply_alarm_disable && ovr_s_r[1];
        cond[3] = !supply_alarm_disable && und_s_r[1];
    end

    always @* begin
        if (append_flags) begin
            load_word = {result_code, act_r, trip_r, `AAR_FLAGS_W'h00};
        end else begin
            load_word = {result_code, `AAR_ZERO16};
        end
        if (rd_flags_r) begin
            load_word = {`AAR_ZERO16, act_r, trip_r, `AAR_FLAGS_W'h00};
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cs_s_r <= 2'h3;
            sck_s_r <= 2'h0;
            sdi_s_r <= 2'h0;
            cs_d_r <= 1'b1;
            sck_d_r <= 1'b0;
            si_r <= 1'b0;
            ovr_s_r <= 2'h0;
            und_s_r <= 2'h0;
        end else begin
            cs_s_r <= {cs_s_r[0], convert_start_chip_select};
            sck_s_r <= {sck_s_r[0], sclk};
            sdi_s_r <= {sdi_s_r[0], sdi};
            cs_d_r <= cs_s_r[1];
            sck_d_r <= sck_s_r[1];
            si_r <= sdi_s_r[1];
            ovr_s_r <= {ovr_s_r[0], supply_over_trip};
            und_s_r <= {und_s_r[0], supply_under_trip};
        end
    end

    // Conversion sequencing and flags
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            converting <= 1'b0;
            conv_start <= 1'b0;
            conv_cnt_r <= {(`AAR_CNT_W+5){1'b0}};
            act_r <= 4'h0;
            trip_r <= 4'h0;
            alarm_flags <= `AAR_FLAGS_W'h00;
            result_code <= `AAR_ZERO16;
            shared_alarm_output_pin <= 1'b0;
            internal_ref_disable <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            if (internal_ref_disable_we) begin
                internal_ref_disable <= internal_ref_disable_in;
            end
            if (cs_rise && !converting) begin
                converting <= 1'b1;
                conv_start <= 1'b1;
                conv_cnt_r <= CONV_CYC[`AAR_CNT_W+4:0] - 1'b1;
            end else if (converting && conv_cnt_r != {(`AAR_CNT_W+5){1'b0}}) begin
                conv_cnt_r <= conv_cnt_r - 1'b1;
            end
            if (conv_done) begin
                converting <= 1'b0;
                result_code <= fifo_data;
                act_r <= cond;
            end
            // Read clears tripped bits; a new trip wins
            trip_r <= (trip_r & ~{4{cs_rise && rd_flags_r}})
                | ({4{conv_done}} & cond);
            alarm_flags <= {act_r, trip_r};
            shared_alarm_output_pin <= (multifunction_pin_select == `AAR_PIN_ALARM)
                && ((act_r & en_mask) != 4'h0);
        end
    end

    // 32-bit frame: out on sclk rise, in on sclk fall
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sh_r <= {`AAR_FRAME_W{1'b0}};
            bit_cnt_r <= {`AAR_CNT_W{1'b0}};
            primary_serial_output <= 1'b0;
            primary_serial_output_oe <= 1'b0;
            frame_rx_word <= {`AAR_FRAME_W{1'b0}};
            frame_rx_valid <= 1'b0;
            rd_flags_r <= 1'b0;
        end else begin
            frame_rx_valid <= 1'b0;
            if (cs_fall) begin
                sh_r <= load_word;
                bit_cnt_r <= {`AAR_CNT_W{1'b0}};
                primary_serial_output_oe <= 1'b1;
                primary_serial_output <= load_word[`AAR_FRAME_W-1];
            end else if (!cs_q) begin
                if (sck_rise) begin
                    primary_serial_output <= sh_r[`AAR_FRAME_W-1];
                end
                if (sck_fall) begin
                    sh_r <= {sh_r[`AAR_FRAME_W-2:0], si_r};
                    bit_cnt_r <= bit_cnt_r + 1'b1;
                end
            end
            if (cs_rise) begin
                primary_serial_output_oe <= 1'b0;
                if (bit_cnt_r == `AAR_FRAME_BITS) begin
                    frame_rx_word <= sh_r;
                    frame_rx_valid <= 1'b1;
                    rd_flags_r <= (sh_r[`AAR_FRAME_W-1:`AAR_FRAME_W-8] == `AAR_CMD_RD_FLAGS);
                end else begin
                    rd_flags_r <= 1'b0;
                end
            end
        end
    end
endmodule

// ---- verilog/aar_map.vh ----
// Constants for the alarm and result coding block
`ifndef AAR_MAP_VH
`define AAR_MAP_VH
`define AAR_RES_W 16
`define AAR_FRAME_W 32
`define AAR_FRAME_BITS 6'h20
`define AAR_CNT_W 6
`define AAR_PIN_ALARM 2'h1
`define AAR_FLAGS_W 8
`define AAR_FIFO_DEPTH 4
`define AAR_CONV_NS 1000
`define AAR_CLK_NS 50
`define AAR_CONV_CYC ((`AAR_CONV_NS + `AAR_CLK_NS - 1) / `AAR_CLK_NS)
`define AAR_ZERO16 16'h0000
`define AAR_ONE17 17'h00001
`define AAR_CMD_RD_FLAGS 8'hA5
`endif

// ---- verilog/aar_fifo.v ----
// Small valid/ready FIFO for conversion results
module aar_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    mclk,
    rst,
    in_data,
    in_valid,
    in_ready,
    out_data,
    out_valid,
    out_ready
);
    input wire mclk;
    input wire rst;
    input wire [WIDTH-1:0] in_data;
    input wire in_valid;
    output wire in_ready;
    output wire [WIDTH-1:0] out_data;
    output wire out_valid;
    input wire out_ready;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    reg [AW:0] cnt_nxt;
    reg in_ready_r;
    wire push;
    wire pop;

    assign in_ready = in_ready_r;
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge mclk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always @* begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            in_ready_r <= 1'b1;
        end else begin
            // Ready registered from the next count
            cnt_r <= cnt_nxt;
            in_ready_r <= (cnt_nxt != DEPTH[AW:0]);
            if (push) begin
                wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
        end
    end
endmodule

// ---- bench/aar_alarm_sva.sv ----
// Assertion checker for the alarm and result coding block
module aar_alarm_sva #(
    parameter CONV_CYC = 20
) (
    input wire mclk,
    input wire rst,
    input wire [15:0] high_threshold,
    input wire [15:0] low_threshold,
    input wire [15:0] hysteresis,
    input wire [1:0] multifunction_pin_select,
    input wire input_alarm_disable,
    input wire supply_alarm_disable,
    input wire convert_start_chip_select,
    input wire primary_serial_output_oe,
    input wire shared_alarm_output_pin,
    input wire converting,
    input wire conv_start,
    input wire [7:0] alarm_flags,
    input wire [15:0] result_code
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire [17:0] res_x = {2'h0, result_code};
    wire [17:0] hys_x = {2'h0, hysteresis} + 18'h00001;
    wire [3:0] en_mask = {{2{~supply_alarm_disable}}, {2{~input_alarm_disable}}};
    a_high_set: assert property ($fell(converting) && result_code > high_threshold
        && !input_alarm_disable |=> alarm_flags[4]) else $error("high alarm not set");
    a_high_clear: assert property ($fell(converting)
        && res_x + hys_x <= {2'h0, high_threshold} |=> !alarm_flags[4])
        else $error("high alarm not cleared");
    a_low_set: assert property ($fell(converting) && result_code < low_threshold
        && !input_alarm_disable |=> alarm_flags[5]) else $error("low alarm not set");
    a_low_clear: assert property ($fell(converting)
        && res_x >= {2'h0, low_threshold} + hys_x |=> !alarm_flags[5])
        else $error("low alarm not cleared");
    a_flags_paired: assert property ($changed(alarm_flags) |->
        (alarm_flags[7:4] & ~$past(alarm_flags[7:4]) & ~alarm_flags[3:0]) == 4'h0)
        else $error("active set without tripped");
    a_supply_off: assert property ($fell(converting) && supply_alarm_disable
        |=> alarm_flags[7:6] == 2'h0) else $error("disabled supply alarm active");
    a_pin_off: assert property ((multifunction_pin_select != 2'h1) [*3]
        |-> !shared_alarm_output_pin) else $error("alarm on pin not selected");
    a_pin_level: assert property (($stable(alarm_flags) && $stable(en_mask)
        && multifunction_pin_select == 2'h1) [*3]
        |-> shared_alarm_output_pin == |(alarm_flags[7:4] & en_mask))
        else $error("alarm pin level wrong");
    a_oe_idle: assert property (convert_start_chip_select [*5]
        |-> !primary_serial_output_oe) else $error("output enabled outside frame");
    a_no_restart: assert property (converting [*3] |-> !conv_start)
        else $error("conversion restarted while busy");
    c_high: cover property ($fell(converting) && alarm_flags[4]);
    c_low: cover property ($fell(converting) && alarm_flags[5]);
    c_pin: cover property ($rose(shared_alarm_output_pin));
endmodule
bind aar_alarm aar_alarm_sva #(.CONV_CYC(CONV_CYC)) aar_alarm_sva_i (.*);

// ---- bench/aar_host_model.sv ----
// Behavioural host controller driving serial frames into the block
module aar_host_model (
    input wire mclk,
    input wire primary_serial_output,
    output logic convert_start_chip_select,
    output logic sclk,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        convert_start_chip_select = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Full-duplex frame, MSB first, sclk idle low outside frames
    task automatic frame(input logic [31:0] tx, output logic [31:0] rx, input int half);
        @(negedge mclk);
        #13 convert_start_chip_select = 1'b0;
        #400;
        // Data set at fall, block presents a bit on rise, host takes it before fall
        for (int i = 31; i >= 0; i--) begin
            sdi = tx[i];
            #(half) sclk = 1'b1;
            #(half) rx[i] = primary_serial_output;
            sclk = 1'b0;
        end
        #200 convert_start_chip_select = 1'b1;
        sdi = ~sdi;
    endtask
    // Short select pulse while a conversion runs
    task automatic abort_frame;
        repeat (5) @(negedge mclk);
        convert_start_chip_select = 1'b0;
        #150 convert_start_chip_select = 1'b1;
    endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the alarm and result coding block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] HI = 16'h8000, LO = 16'h2000, HY = 16'h0010;
    logic mclk = 1'b0, rst = 1'b1, vld = 1'b0, sup_dis = 1'b0, ref_in = 1'b0, ref_we = 1'b0;
    logic over = 1'b0, under = 1'b0, cmd = 1'b0, app = 1'b0, in_dis = 1'b0;
    logic [1:0] sel = 2'h1, st = 2'h0;
    logic [15:0] din = 16'h0000, last = 16'h0000;
    logic [15:0] q[$];
    logic [15:0] corner[8] = '{16'h8001, 16'h7FF0, 16'h7FEF, 16'h1FFF,
        16'h2010, 16'h2011, 16'hFFFF, 16'h0000};
    logic [3:0] act = 4'h0, trip = 4'h0;
    logic [31:0] seed = 32'h29C24ADA, tx, rx;
    wire ready, cs, sclk, sdi, sdo, pin, ref_out, conv, start, oe, rxv;
    wire [7:0] flags;
    wire [31:0] rx_word;
    wire [15:0] res;
    int num_errors = 0, tests_run = 0, starts = 0, frames = 0, oe_bad = 0;
    aar_alarm #(.CONV_CYC(20)) aar_alarm_i (.mclk(mclk), .rst(rst), .conv_result(din),
        .conv_result_valid(vld), .conv_result_ready(ready), .high_threshold(HI),
        .low_threshold(LO), .hysteresis(HY), .multifunction_pin_select(sel),
        .input_alarm_disable(in_dis), .supply_alarm_disable(sup_dis),
        .internal_ref_disable_in(ref_in), .internal_ref_disable_we(ref_we),
        .append_flags(app), .supply_over_trip(over), .supply_under_trip(under),
        .convert_start_chip_select(cs), .sclk(sclk), .sdi(sdi), .primary_serial_output(sdo),
        .primary_serial_output_oe(oe), .shared_alarm_output_pin(pin),
        .internal_ref_disable(ref_out), .converting(conv), .conv_start(start),
        .alarm_flags(flags), .frame_rx_word(rx_word), .frame_rx_valid(rxv), .result_code(res));
    aar_host_model aar_host_model_i (.mclk(mclk), .primary_serial_output(sdo),
        .convert_start_chip_select(cs), .sclk(sclk), .sdi(sdi));
    always #25 mclk = ~mclk;
    always @(negedge mclk) begin
        if (start === 1'b1) starts++;
        if (rxv === 1'b1) frames++;
        if (sclk === 1'b1 && oe !== 1'b1) oe_bad++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] in_next(input logic [1:0] s, input logic [15:0] r);
        logic [17:0] x;
        x = {2'h0, r} + {2'h0, HY} + 18'h00001;
        in_next[0] = s[0] ? (x > {2'h0, HI}) : (r > HI);
        in_next[1] = s[1] ? ({2'h0, r} < {2'h0, LO} + x - {2'h0, r}) : (r < LO);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic push(input logic [15:0] r);
        int n;
        @(negedge mclk);
        din = r;
        vld = 1'b1;
        for (n = 0; n < 100 && ready !== 1'b1; n++) @(negedge mclk);
        if (n == 100) num_errors++;
        @(negedge mclk);
        vld = 1'b0;
        q.push_back(r);
    endtask
    task automatic wait_conv;
        int n;
        repeat (6) @(negedge mclk);
        for (n = 0; n < 200 && conv !== 1'b0; n++) @(negedge mclk);
        if (n == 200) num_errors++;
        repeat (3) @(negedge mclk);
    endtask
    initial begin
        #1000000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        chk("ref disable", 32'h0, ref_out);
        ref_in = 1'b1;
        ref_we = 1'b1;
        @(negedge mclk);
        ref_we = 1'b0;
        @(negedge mclk);
        chk("ref disable", 32'h1, ref_out);
        for (int i = 0; i < 4; i++) push(corner[i]);
        chk("fifo ready", 32'h0, ready);
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            sel = k < 8 ? 2'h1 : k[1:0];
            sup_dis = seed[2];
            over = seed[3];
            under = seed[4];
            app = seed[5];
            in_dis = k >= 8 && seed[6];
            tx = (k % 4 == 1) ? 32'hA5000000 : {8'h00, seed[31:8]};
            aar_host_model_i.frame(tx, rx, 200);
            chk("serial word", cmd ? {16'h0000, act, trip, 8'h00}
                : {last, app ? {act, trip} : 8'h00, 8'h00}, rx);
            if (cmd) trip = 4'h0;
            cmd = tx[31:24] == 8'hA5;
            if (k % 4 == 2) aar_host_model_i.abort_frame();
            wait_conv();
            st = in_dis ? 2'h0 : in_next(st, q[0]);
            act = {under & ~sup_dis, over & ~sup_dis, st};
            trip = trip | act;
            last = q.pop_front();
            chk("result", last, res);
            chk("flags", {act, trip}, flags);
            chk("alarm pin", sel == 2'h1 && |act, pin);
            chk("frame word", tx, rx_word);
            push(k < 4 ? corner[k + 4] : seed[23:8]);
        end
        chk("starts", 32'd16, starts);
        chk("frames", 32'd16, frames);
        chk("oe in frame", 32'd0, oe_bad);
        end_sim();
    end
endmodule
